// ===== design/timer16_with_capture_unit.sv
// 16-bit timer/counter with edge capture unit and register port.
// assumes the bus is synchronous to core_clk_i, pins are synchronised here; ce_i freezes all.
//
// Decided for this implementation: the address-and-strobe port.
`include "timer16_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module timer16_with_capture_unit (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire timer16_pkg::reg_req_t bus_req_i,
	output logic [7:0] rd_data_o,
	input wire logic timer_reset_trig_i,
	input wire logic capture_pin_i,
	input wire logic [1:0] osc_pin_i,
	output timer16_pkg::osc_pins_t osc_pins_o,
	output logic overflow_flag_o,
	output logic capture_flag_o
);

	// software-visible state
	logic [15:0] cnt_q, cnt_d; // timer_count
	logic [7:0] tctl_q, tctl_d; // timer_control
	logic [15:0] capt_q, capt_d; // capture_value
	logic [3:0] cmode_q, cmode_d; // capture_mode_field
	logic [7:0] flags_q, flags_d; // periph_irq_flags
	logic [7:0] ien_q, ien_d; // periph_irq_enables, storage only
	logic fw_clk_q, fw_clk_d; // firmware_count_clock_bit
	logic fw_capt_q, fw_capt_d; // capture_pin_data_bit
	logic cdir_q, cdir_d; // capture_pin_direction bit
	logic [1:0] pdir_q, pdir_d; // port_direction for the osc pins
	logic [1:0] pdat_q, pdat_d; // port_data latch for the osc pins
	logic [7:0] rd_q, rd_d; // read data, one cycle late

	// edge and prescale state
	logic cpin_s1_q, cpin_s2_q; // capture pin chain
	logic csrc_prev_q; // previous capture event source level
	logic [3:0] presc_q, presc_d; // capture edge prescaler
	logic clk_s1_q, clk_s2_q, clk_prev_q; // count clock chain
	logic clk_raw_q; // one-flop sample for async mode

	// decoded controls
	logic run, clksel, async_mode, oscen;
	timer16_pkg::count_src_t src;
	logic src_level, clk_level, clk_rise;
	logic cap_mode, cap_level, cap_rise, cap_fall, cap_event;
	logic tick, wr, rd;
	logic [7:0] a, wd;

	assign a = bus_req_i.addr;
	assign wd = bus_req_i.wdata;
	assign wr = bus_req_i.we;
	assign rd = bus_req_i.re;
	assign run = tctl_q[`TC_RUN_BIT];
	assign clksel = tctl_q[`TC_CLKSEL_BIT];
	assign async_mode = tctl_q[`TC_ASYNC_BIT];
	assign oscen = tctl_q[`TC_OSCEN_BIT];

	// count source pick, oscillator wins over the firmware bit
	always_comb begin
		if (oscen) begin
			src = timer16_pkg::SRC_OSC;
		end else if (tctl_q[`TC_FWSRC_BIT]) begin
			src = timer16_pkg::SRC_FW;
		end else begin
			src = timer16_pkg::SRC_PIN;
		end
	end

	// source level, clock-in pin is osc_pin_i[0], osc input is [1]
	always_comb begin
		case (src)
			timer16_pkg::SRC_FW: src_level = fw_clk_q;
			timer16_pkg::SRC_OSC: src_level = osc_pin_i[1];
			default: src_level = osc_pin_i[0];
		endcase
	end

	// async mode skips the second stage: faster, but capture may miss
	assign clk_level = async_mode ? clk_raw_q : clk_s2_q;
	assign clk_rise = clk_level & ~clk_prev_q;
	// timer mode ticks every cycle, counter mode on rising edges
	assign tick = run & (clksel ? clk_rise : 1'b1);

	// capture unit only active for 01xx codes
	// compare and pwm codes fall outside 01xx and leave the unit idle
	assign cap_mode = (cmode_q[3:2] == `CM_CAPT_HI);
	// output direction: the data bit stands in for the pin
	assign cap_level = cdir_q ? cpin_s2_q : fw_capt_q;
	assign cap_rise = cap_level & ~csrc_prev_q;
	assign cap_fall = ~cap_level & csrc_prev_q;

	// prescaler and event qualification
	// the prescaler counts rises only in the 4th- and 16th-rise settings; the 4th-rise setting
	// looks only at its low two bits, so a switch between prescale settings
	// can fire early, which software avoids by passing through the off code
	always_comb begin
		presc_d = presc_q;
		cap_event = 1'b0;
		if (!cap_mode) begin
			presc_d = 4'h0;
		end else begin
			case (cmode_q)
				`CM_FALL: cap_event = cap_fall;
				`CM_RISE: cap_event = cap_rise;
				`CM_RISE4: begin
					// count kept across prescale switches
					if (cap_rise) begin
						cap_event = ((presc_q & `PRESC_LAST4) == `PRESC_LAST4);
						presc_d = presc_q + 4'h1;
					end
				end
				default: begin
					if (cap_rise) begin
						cap_event = (presc_q == `PRESC_LAST16);
						presc_d = presc_q + 4'h1;
					end
				end
			endcase
		end
	end

	// register writes, counting, capture, flags
	// hardware sets in this process come last so they beat software clears
	// landing on the same edge; a flag event is never lost to a clear
	always_comb begin
		cnt_d = cnt_q;
		tctl_d = tctl_q;
		capt_d = capt_q;
		cmode_d = cmode_q;
		flags_d = flags_q;
		ien_d = ien_q;
		fw_clk_d = fw_clk_q;
		fw_capt_d = fw_capt_q;
		cdir_d = cdir_q;
		pdir_d = pdir_q;
		pdat_d = pdat_q;
		// counting; a software byte write below takes priority
		if (timer_reset_trig_i) begin
			cnt_d = 16'h0000;
		end else if (tick) begin
			cnt_d = cnt_q + 16'h0001;
		end
		// software writes
		if (wr) begin
			if (a == `OFS_COUNT_LOW) begin
				cnt_d[7:0] = wd;
			end else if (a == `OFS_COUNT_HIGH) begin
				cnt_d[15:8] = wd;
			end else if (a == `OFS_TIMER_CONTROL) begin
				tctl_d = wd & `TC_USED_MASK;
			end else if (a == `OFS_CAPT_LOW) begin
				capt_d[7:0] = wd;
			end else if (a == `OFS_CAPT_HIGH) begin
				capt_d[15:8] = wd;
			end else if (a == `OFS_CAPT_CONTROL) begin
				cmode_d = wd[3:0];
			end else if (a == `OFS_IRQ_FLAGS) begin
				flags_d[`IRQ_OVF_BIT] = wd[`IRQ_OVF_BIT];
				flags_d[`IRQ_CAPT_BIT] = wd[`IRQ_CAPT_BIT];
			end else if (a == `OFS_IRQ_ENABLES) begin
				ien_d = wd;
			end else if (a == `OFS_FW_PIN_DATA) begin
				fw_clk_d = wd[`FW_CLK_BIT];
				fw_capt_d = wd[`FW_CAPT_BIT];
			end else if (a == `OFS_CAPT_PIN_DIR) begin
				cdir_d = wd[`CAPT_DIR_BIT];
			end else if (a == `OFS_PORT_DIR) begin
				pdir_d = wd[2:1];
			end else if (a == `OFS_PORT_DATA) begin
				pdat_d = wd[2:1];
			end else begin
				cnt_d = cnt_d; // unmapped write ignored
			end
		end
		// wrap sets overflow; set beats a same-cycle software clear
		if (tick && !timer_reset_trig_i && cnt_q == 16'hFFFF) begin
			flags_d[`IRQ_OVF_BIT] = 1'b1;
		end
		// capture overwrites unread value and flags it
		if (cap_event) begin
			capt_d = cnt_q;
			flags_d[`IRQ_CAPT_BIT] = 1'b1;
		end
	end

	// read mux, unmapped addresses read zero
	// reads see the state before this edge's update, so a count read
	// returns the value the timer held when the strobe was sampled
	always_comb begin
		rd_d = 8'h00;
		if (rd) begin
			if (a == `OFS_COUNT_LOW) begin
				rd_d = cnt_q[7:0];
			end else if (a == `OFS_COUNT_HIGH) begin
				rd_d = cnt_q[15:8];
			end else if (a == `OFS_TIMER_CONTROL) begin
				rd_d = tctl_q;
			end else if (a == `OFS_CAPT_LOW) begin
				rd_d = capt_q[7:0];
			end else if (a == `OFS_CAPT_HIGH) begin
				rd_d = capt_q[15:8];
			end else if (a == `OFS_CAPT_CONTROL) begin
				rd_d = {4'h0, cmode_q};
			end else if (a == `OFS_IRQ_FLAGS) begin
				rd_d = flags_q;
			end else if (a == `OFS_IRQ_ENABLES) begin
				rd_d = ien_q;
			end else if (a == `OFS_FW_PIN_DATA) begin
				// capture data bit reads the effective pin level
				rd_d = {5'h00, cap_level, 1'b0, fw_clk_q};
			end else if (a == `OFS_CAPT_PIN_DIR) begin
				rd_d = {5'h00, cdir_q, 2'h0};
			end else if (a == `OFS_PORT_DIR) begin
				rd_d = {5'h00, pdir_q, 1'b0};
			end else if (a == `OFS_PORT_DATA) begin
				rd_d = {5'h00, pdat_q, 1'b0};
			end else begin
				rd_d = 8'h00;
			end
		end
	end

	// oscillator pin drive; osc enable overrides direction bits
	// built from next-state values so the registered pins follow a
	// register write on the same edge instead of one cycle behind
	timer16_pkg::osc_pins_t pins_d, pins_q;
	always_comb begin
		pins_d.out = pdat_d;
		if (tctl_d[`TC_OSCEN_BIT]) begin
			pins_d.oe = 2'h0;
		end else begin
			pins_d.oe = ~pdir_d;
		end
	end

	// state registers, all frozen while ce_i is low
	// reset ignores ce_i so a stalled clock enable cannot block a reset
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			cnt_q <= 16'h0000;
			tctl_q <= `RST_BYTE;
			capt_q <= 16'h0000;
			cmode_q <= `CM_OFF;
			flags_q <= `RST_BYTE;
			ien_q <= `RST_BYTE;
			fw_clk_q <= 1'b0;
			fw_capt_q <= 1'b0;
			cdir_q <= `RST_DIR_IN;
			pdir_q <= `RST_PORT_DIR;
			pdat_q <= 2'h0;
			rd_q <= 8'h00;
			presc_q <= 4'h0;
			pins_q <= '0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			tctl_q <= tctl_d;
			capt_q <= capt_d;
			cmode_q <= cmode_d;
			flags_q <= flags_d;
			ien_q <= ien_d;
			fw_clk_q <= fw_clk_d;
			fw_capt_q <= fw_capt_d;
			cdir_q <= cdir_d;
			pdir_q <= pdir_d;
			pdat_q <= pdat_d;
			rd_q <= rd_d;
			presc_q <= presc_d;
			pins_q <= pins_d;
		end
	end

	// synchronisers and edge history; first stages feed only second
	// clk_raw_q is a single-stage sample used only in async counter mode:
	// it trims a cycle of latency but can go metastable, which is why
	// captures are not promised while counting asynchronously
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			cpin_s1_q <= 1'b0;
			cpin_s2_q <= 1'b0;
			csrc_prev_q <= 1'b0;
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_raw_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else if (ce_i) begin
			cpin_s1_q <= capture_pin_i;
			cpin_s2_q <= cpin_s1_q;
			csrc_prev_q <= cap_level;
			clk_s1_q <= src_level;
			clk_s2_q <= clk_s1_q;
			clk_raw_q <= src_level;
			clk_prev_q <= clk_level;
		end
	end

	// every output comes straight from a register
	assign rd_data_o = rd_q;
	assign osc_pins_o = pins_q;
	assign overflow_flag_o = flags_q[`IRQ_OVF_BIT];
	assign capture_flag_o = flags_q[`IRQ_CAPT_BIT];

endmodule

`default_nettype wire

// ===== inc/timer16_defines.svh
// register offsets, field positions, reset values and mode codes
// for the 16-bit timer with capture unit.
// assumes an 8-bit register address space reached over a plain port.
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// register offsets
`define OFS_IRQ_FLAGS 8'h0C
`define OFS_COUNT_LOW 8'h0E
`define OFS_COUNT_HIGH 8'h0F
`define OFS_TIMER_CONTROL 8'h10
`define OFS_CAPT_LOW 8'h15
`define OFS_CAPT_HIGH 8'h16
`define OFS_CAPT_CONTROL 8'h17
`define OFS_FW_PIN_DATA 8'h18
`define OFS_CAPT_PIN_DIR 8'h19
`define OFS_PORT_DIR 8'h1A
`define OFS_PORT_DATA 8'h1B
`define OFS_IRQ_ENABLES 8'h8C

// timer_control fields
`define TC_RUN_BIT 0
`define TC_CLKSEL_BIT 1
`define TC_ASYNC_BIT 2
`define TC_OSCEN_BIT 3
`define TC_FWSRC_BIT 4
`define TC_USED_MASK 8'h1F

// flag and data bit positions
`define IRQ_OVF_BIT 0
`define IRQ_CAPT_BIT 2
`define FW_CLK_BIT 0
`define FW_CAPT_BIT 2
`define CAPT_DIR_BIT 2

// capture mode field codes
`define CM_OFF 4'h0
`define CM_CAPT_HI 2'h1
`define CM_FALL 4'h4
`define CM_RISE 4'h5
`define CM_RISE4 4'h6
`define CM_RISE16 4'h7
`define PRESC_LAST4 4'h3
`define PRESC_LAST16 4'hF

// reset values
`define RST_BYTE 8'h00
`define RST_DIR_IN 1'h1
`define RST_PORT_DIR 2'h3

`endif

// ===== inc/timer16_pkg.sv
// types shared by the timer with capture unit.
// assumes timer16_defines.svh holds all numbers.
package timer16_pkg;

	// one register access from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} reg_req_t;

	// count clock source in counter mode
	typedef enum logic [1:0] {
		SRC_PIN,
		SRC_FW,
		SRC_OSC
	} count_src_t;

	// two oscillator/clock port pins, bit 0 is the clock-in pin
	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} osc_pins_t;

endpackage

// ===== testbench/timer16_with_capture_unit_asserts.sv
// port checker for the timer with capture unit, bound into the design.
// assumes ce_i stays high while the bench runs.
`timescale 1ns/1ps
`default_nettype none
module timer16_asserts (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire timer16_pkg::reg_req_t bus_req_i,
	input wire logic [7:0] rd_data_o,
	input wire timer16_pkg::osc_pins_t osc_pins_o,
	input wire logic overflow_flag_o,
	input wire logic capture_flag_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	logic flag_wr; // software write of the flag register
	logic re;
	logic [7:0] ad;
	assign flag_wr = bus_req_i.we && bus_req_i.addr == 8'h0C;
	assign re = bus_req_i.re;
	assign ad = bus_req_i.addr;
	cflag_hold_a: assert property ($fell(capture_flag_o) |-> $past(flag_wr))
		else $error("capture flag dropped without a write");
	ovf_hold_a: assert property ($fell(overflow_flag_o) |-> $past(flag_wr))
		else $error("overflow flag dropped without a write");
	rd_idle_a: assert property (!$past(re) |-> rd_data_o == 8'h00)
		else $error("read data outside its cycle");
	rd_unmap_a: assert property ($past(re && ad inside {[8'h20:8'h7F]}) |-> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	ctrl_rsv_a: assert property ($past(re && ad == 8'h10) |-> rd_data_o[7:5] == 3'h0)
		else $error("control spare bits set");
	mode_rb_a: assert property ((bus_req_i.we && ad == 8'h17) ##2 (re && ad == 8'h17)
		|=> rd_data_o == {4'h0, $past(bus_req_i.wdata[3:0], 3)}) else $error("mode readback");
	pin_dir_a: assert property ((bus_req_i.we && ad == 8'h1A) |-> ##2
		(osc_pins_o.oe == 2'h0 || osc_pins_o.oe == ~$past(bus_req_i.wdata[2:1], 2))) else $error("pin enable");
	rst_val_a: assert property ($rose(nrst_i) |-> osc_pins_o.oe == 2'h0 && !overflow_flag_o && !capture_flag_o)
		else $error("reset state wrong");
endmodule
bind timer16_with_capture_unit timer16_asserts chk_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .osc_pins_o(osc_pins_o),
	.overflow_flag_o(overflow_flag_o), .capture_flag_o(capture_flag_o));
`default_nettype wire

// ===== testbench/ext_signal_source.sv
// outside signal source on the capture pin and the oscillator pins.
// assumes half_i holds steady for a burst; zero parks the capture and clock-in lines.
`timescale 1ns/1ps
`default_nettype none
module ext_signal_source (
	input wire logic clk_i,
	input wire logic [3:0] half_i,
	output logic cap_o,
	output logic [1:0] osc_o
);
	logic [3:0] cnt_q;
	initial begin
		cnt_q = 4'h0;
		cap_o = 1'b0;
		osc_o = 2'h0;
	end
	// square wave in bursts, parked low so each burst starts from low
	always @(posedge clk_i) begin
		if (half_i == 4'h0) begin
			cnt_q <= 4'h0;
			cap_o <= 1'b0;
		end else if (cnt_q == half_i - 4'h1) begin
			cnt_q <= 4'h0;
			cap_o <= ~cap_o;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// clock-in pin follows the burst, crystal side runs free
	always @(posedge clk_i) osc_o <= {~osc_o[1], cap_o};
endmodule
`default_nettype wire

// ===== testbench/timer16_with_capture_unit_tb.sv
// bench for the timer with capture unit: bus tasks, source model, checks.
// assumes one clock; ce_i held high throughout.
`timescale 1ns/1ps
`default_nettype none
module timer16_with_capture_unit_tb;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	timer16_pkg::reg_req_t req = '0;
	timer16_pkg::osc_pins_t pins;
	logic [7:0] rd, a, b;
	logic [3:0] half = 4'h0;
	logic [1:0] osc;
	logic trig = 1'b0;
	logic cap, ovf, cfl, prev;
	logic [31:0] seed = 32'h000156E5;
	logic [15:0] v;
	int err_total = 0;
	int tests_run = 0;
	int n;
	always #2 core_clk_i = ~core_clk_i;
	timer16_with_capture_unit uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.bus_req_i(req), .rd_data_o(rd), .timer_reset_trig_i(trig), .capture_pin_i(cap),
		.osc_pin_i(osc), .osc_pins_o(pins), .overflow_flag_o(ovf), .capture_flag_o(cfl));
	ext_signal_source src (.clk_i(core_clk_i), .half_i(half), .cap_o(cap), .osc_o(osc));
	// xorshift values, repeatable run to run
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	// pin changes from a low pin up to the first capture
	function automatic int edges_for(input logic [3:0] m);
		case (m)
			4'h4: return 2;
			4'h5: return 1;
			4'h6: return 7;
			default: return 31;
		endcase
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge core_clk_i);
		req <= '{ad, d, 1'b1, 1'b0};
		@(posedge core_clk_i);
		req <= '0;
	endtask
	// read strobe one cycle, data taken in the cycle after
	task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
		@(posedge core_clk_i);
		req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk_i);
		req <= '0;
		#1 chk(rd, e);
	endtask
	// plain read returning the byte, for deltas between two reads
	task automatic rdv(input logic [7:0] ad, output logic [7:0] d);
		@(posedge core_clk_i);
		req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk_i);
		req <= '0;
		#1 d = rd;
	endtask
	// bounded wait on a flag output; running out ends the run
	task automatic wait_flag(input logic sel);
		for (int i = 0; i < 600; i++) begin
			@(posedge core_clk_i);
			#1;
			if ((sel ? cfl : ovf) === 1'b1) return;
		end
		err_total++;
		stop_test();
	endtask
	initial begin
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rdc(8'h10, 8'h00);
		rdc(8'h17, 8'h00);
		rdc(8'h40, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			wr(8'h0E, v[7:0]);
			wr(8'h0F, v[15:8]);
			rdc(8'h0E, v[7:0]);
			rdc(8'h0F, v[15:8]);
		end
		$display("count access done");
		wr(8'h0E, 8'h10);
		wr(8'h10, 8'h01);
		rdv(8'h0E, a);
		rdv(8'h0E, b);
		chk(8'(b - a), 16'h0002);
		wr(8'h10, 8'h00);
		wr(8'h0E, 8'hF0);
		wr(8'h0F, 8'hFF);
		wr(8'h10, 8'h01);
		wait_flag(1'b0);
		wr(8'h10, 8'h00);
		chk(ovf, 16'h0001);
		rdc(8'h0F, 8'h00);
		wr(8'h0C, 8'h00);
		rdc(8'h0C, 8'h00);
		chk(ovf, 16'h0000);
		wr(8'h0F, 8'h12);
		@(posedge core_clk_i);
		trig <= 1'b1;
		@(posedge core_clk_i);
		trig <= 1'b0;
		rdc(8'h0F, 8'h00);
		$display("timer done");
		wr(8'h10, 8'h00);
		wr(8'h19, 8'h04);
		for (int m = 4; m < 8; m++) begin
			v = rnd();
			wr(8'h17, 8'h00);
			wr(8'h0E, v[7:0]);
			wr(8'h0F, v[15:8]);
			wr(8'h17, 8'(m));
			rdc(8'h17, 8'(m));
			wr(8'h0C, 8'h00);
			rdc(8'h0C, 8'h00);
			n = 0;
			prev = cap;
			half <= 4'h6;
			for (int i = 0; i < 600 && cfl !== 1'b1; i++) begin
				@(posedge core_clk_i);
				#1;
				n += (cap !== prev);
				prev = cap;
			end
			half <= 4'h0;
			if (cfl !== 1'b1) begin
				err_total++;
				stop_test();
			end
			chk(16'(n), 16'(edges_for(4'(m))));
			rdc(8'h15, v[7:0]);
			rdc(8'h16, v[15:8]);
			repeat (12) @(posedge core_clk_i);
		end
		$display("capture modes done");
		wr(8'h19, 8'h00);
		wr(8'h17, 8'h00);
		wr(8'h17, 8'h05);
		wr(8'h0C, 8'h00);
		wr(8'h18, 8'h04);
		wait_flag(1'b1);
		rdc(8'h16, v[15:8]);
		wr(8'h17, 8'h09);
		wr(8'h0C, 8'h00);
		wr(8'h18, 8'h00);
		wr(8'h18, 8'h04);
		wr(8'h18, 8'h00);
		rdc(8'h0C, 8'h00);
		wr(8'h19, 8'h04);
		wr(8'h17, 8'h00);
		wr(8'h0E, 8'h00);
		wr(8'h10, 8'h13);
		repeat (3) begin
			wr(8'h18, 8'h01);
			wr(8'h18, 8'h00);
		end
		repeat (4) @(posedge core_clk_i);
		rdc(8'h0E, 8'h03);
		wr(8'h0E, 8'h00);
		wr(8'h10, 8'h17);
		repeat (3) begin
			wr(8'h18, 8'h01);
			wr(8'h18, 8'h00);
		end
		repeat (4) @(posedge core_clk_i);
		rdc(8'h0E, 8'h03);
		wr(8'h10, 8'h0B);
		repeat (4) @(posedge core_clk_i);
		rdv(8'h0E, a);
		rdv(8'h0E, b);
		chk(8'(b - a), 16'h0001);
		wr(8'h10, 8'h00);
		wr(8'h1B, 8'h06);
		wr(8'h1A, 8'h00);
		rdc(8'h1A, 8'h00);
		chk(pins.oe, 16'h0003);
		chk(pins.out, 16'h0003);
		wr(8'h10, 8'h08);
		rdc(8'h10, 8'h08);
		chk(pins.oe, 16'h0000);
		$display("pins done");
		stop_test();
	end
endmodule
`default_nettype wire
